// >>> core/rsim_map.svh
// Operation
// - Two-bit maximum recovered-clock rate: 00 unknown, 01 128x, 10 256x, 11 512x.
// - Estimate frame rate, pick rate code, drive it to synth and status.
// - Channel status CRC error flag is bit 7, high on error.
// - Subframe parity error flag is bit 6, high on error.
// - Validity flag bit 5 is low for valid, high for invalid audio.
// - Biphase coding violation flag is bit 4, high on violation.
// - Subcode change flag bit 3 is high when Q-channel data changes.
// - Lock-loss flag bit 2 is high when decoder or synth is unlocked.
// - Subcode CRC error flag is bit 1, high on error.
// - Buffer transfer done flag bit 0 is high when transfer completes.
// - A status flag raises the interrupt only when its enable bit is set.
// - Enable bits mirror flag positions; 0 masks, which is the reset value.
// - Slip is detected only when the tracked port runs in slave mode.
// - Slip tracks the sole sourced port, or port A when both are sourced.
// - Unused status bits always read back as zero.
// - Slip interrupt gated by second mask bit 0, masked after reset.
// - Per-source mode: 00 rising, 01 falling, 10 level, 11 reserved.
`ifndef RSIM_MAP_SVH
`define RSIM_MAP_SVH

`define RSIM_ADDR_RATE 8'h13
`define RSIM_ADDR_ERR 8'h14
`define RSIM_ADDR_SLIP 8'h15
`define RSIM_ADDR_MASK1 8'h16
`define RSIM_ADDR_MASK2 8'h17
`define RSIM_ADDR_MODE1 8'h18
`define RSIM_ADDR_MODE2 8'h19

`define RSIM_RATE_HI_BIT 2
`define RSIM_RATE_LO_BIT 0
`define RSIM_SLIP_BIT 0
`define RSIM_SLIP_MASK_BIT 0

`define RSIM_MASK_RESET 8'h00
`define RSIM_MODE_RESET 8'h00

`define RSIM_CLK_HZ 40000000
`define RSIM_FS_512_MAX_HZ 54000
`define RSIM_FS_256_MAX_HZ 108000
`define RSIM_PERIOD_512_CYC (`RSIM_CLK_HZ / `RSIM_FS_512_MAX_HZ)
`define RSIM_PERIOD_256_CYC (`RSIM_CLK_HZ / `RSIM_FS_256_MAX_HZ)
`define RSIM_FRAME_TIMEOUT_US 100
`define RSIM_FRAME_TIMEOUT_CYC (`RSIM_FRAME_TIMEOUT_US * (`RSIM_CLK_HZ / 1000000))

`endif

// >>> core/rsim_pkg.sv
package rsim_pkg;

    typedef enum logic [1:0] {
        RSIM_RATE_NONE = 2'h0,
        RSIM_RATE_128 = 2'h1,
        RSIM_RATE_256 = 2'h2,
        RSIM_RATE_512 = 2'h3
    } rsim_rate_type;

    typedef enum logic [1:0] {
        RSIM_TRIG_RISE = 2'h0,
        RSIM_TRIG_FALL = 2'h1,
        RSIM_TRIG_LEVEL = 2'h2,
        RSIM_TRIG_RSVD = 2'h3
    } rsim_trig_type;

    typedef enum logic [1:0] {
        RSIM_MEAS_IDLE = 2'b00,
        RSIM_MEAS_FIRST = 2'b01,
        RSIM_MEAS_RUN = 2'b11
    } rsim_meas_type;

    // Field order gives bit 7 down to bit 0 of the error status register
    typedef struct packed {
        logic cs_crc;
        logic parity;
        logic validity;
        logic biphase;
        logic sub_change;
        logic lock_loss;
        logic sub_crc;
        logic xfer_done;
    } rsim_rx_status_type;

    typedef struct packed {
        logic cs_crc_err;
        logic parity_err;
        logic validity_bad;
        logic biphase_err;
        logic subcode_changed;
        logic decoder_locked;
        logic synth_locked;
        logic subcode_crc_err;
        logic xfer_done;
    } rsim_rx_cond_type;

    typedef struct packed {
        logic port_a_src;
        logic port_a_slave;
        logic port_a_slip;
        logic port_b_src;
        logic port_b_slave;
        logic port_b_slip;
    } rsim_slip_type;

endpackage

// >>> core/rsim_status_irq.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsim_map.svh"
module rsim_status_irq
    import rsim_pkg::*;
#(
    parameter int FRAME_TIMEOUT_CYC = `RSIM_FRAME_TIMEOUT_CYC,
    parameter int NUM_SRC = 9
) (
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic [7:0] reg_addr_in,
    input wire logic reg_wr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    input wire rsim_rx_cond_type rx_cond_in,
    input wire logic frame_strobe_in,
    input wire rsim_slip_type slip_in,
    output logic [1:0] recovered_clock_rate_out,
    output logic irq_out
);
    localparam logic [11:0] TH_512 = 12'(`RSIM_PERIOD_512_CYC);
    localparam logic [11:0] TH_256 = 12'(`RSIM_PERIOD_256_CYC);
    localparam logic [11:0] TIMEOUT = 12'(FRAME_TIMEOUT_CYC);

    // ------------------------------------------------------------
    // Frame rate estimate
    // ------------------------------------------------------------
    rsim_meas_type meas;
    rsim_meas_type next_meas;
    logic [11:0] period_cnt;
    logic [11:0] next_period_cnt;
    rsim_rate_type rate;
    rsim_rate_type next_rate;
    logic locked;

    assign locked = rx_cond_in.decoder_locked && rx_cond_in.synth_locked;

    always_comb begin
        next_meas = meas;
        next_rate = rate;
        next_period_cnt = (period_cnt == TIMEOUT) ? period_cnt : period_cnt + 12'h001;
        case (meas)
            RSIM_MEAS_IDLE: begin
                if (frame_strobe_in && locked) begin
                    next_meas = RSIM_MEAS_FIRST;
                    next_period_cnt = 12'h000;
                end
            end
            RSIM_MEAS_FIRST, RSIM_MEAS_RUN: begin
                if (frame_strobe_in) begin
                    next_meas = RSIM_MEAS_RUN;
                    next_period_cnt = 12'h000;
                    // slower frames allow a higher multiple
                    if (period_cnt >= TH_512) begin
                        next_rate = RSIM_RATE_512;
                    end else if (period_cnt >= TH_256) begin
                        next_rate = RSIM_RATE_256;
                    end else begin
                        next_rate = RSIM_RATE_128;
                    end
                end else if (period_cnt == TIMEOUT) begin
                    next_meas = RSIM_MEAS_IDLE;
                    next_rate = RSIM_RATE_NONE;
                end
            end
            default: begin
                next_meas = RSIM_MEAS_IDLE;
                next_rate = RSIM_RATE_NONE;
            end
        endcase
        if (!locked) begin
            next_meas = RSIM_MEAS_IDLE;
            next_rate = RSIM_RATE_NONE;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            meas <= RSIM_MEAS_IDLE;
            period_cnt <= 12'h000;
            rate <= RSIM_RATE_NONE;
        end else begin
            meas <= next_meas;
            period_cnt <= next_period_cnt;
            rate <= next_rate;
        end
    end

    // same code to the synth and the status
    assign recovered_clock_rate_out = rate;

    // ------------------------------------------------------------
    // Status flags
    // ------------------------------------------------------------
    rsim_rx_status_type err_status;
    rsim_rx_status_type next_err_status;
    logic slip_flag;
    logic next_slip_flag;
    logic slip_event;
    logic rd_err;
    logic rd_slip;

    assign rd_err = reg_rd_in && (reg_addr_in == `RSIM_ADDR_ERR);
    assign rd_slip = reg_rd_in && (reg_addr_in == `RSIM_ADDR_SLIP);

    always_comb begin
        next_err_status.cs_crc = rx_cond_in.cs_crc_err;
        next_err_status.parity = rx_cond_in.parity_err;
        next_err_status.validity = rx_cond_in.validity_bad;
        next_err_status.biphase = rx_cond_in.biphase_err;
        next_err_status.sub_change = rx_cond_in.subcode_changed;
        next_err_status.lock_loss = !locked;
        next_err_status.sub_crc = rx_cond_in.subcode_crc_err;
        next_err_status.xfer_done = rx_cond_in.xfer_done;
    end

    always_comb begin
        // port A wins when both are sourced
        if (slip_in.port_a_src) begin
            slip_event = slip_in.port_a_slave && slip_in.port_a_slip;
        end else if (slip_in.port_b_src) begin
            slip_event = slip_in.port_b_slave && slip_in.port_b_slip;
        end else begin
            slip_event = 1'b0;
        end
        // sticky until read, set beats clear
        if (slip_event) begin
            next_slip_flag = 1'b1;
        end else if (rd_slip) begin
            next_slip_flag = 1'b0;
        end else begin
            next_slip_flag = slip_flag;
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            err_status <= '0;
            slip_flag <= 1'b0;
        end else begin
            err_status <= next_err_status;
            slip_flag <= next_slip_flag;
        end
    end

    // ------------------------------------------------------------
    // Mask and mode registers
    // ------------------------------------------------------------
    logic [7:0] mask1;
    logic [7:0] next_mask1;
    logic mask2;
    logic next_mask2;
    logic [7:0] mode1;
    logic [7:0] next_mode1;
    logic [7:0] mode2;
    logic [7:0] next_mode2;

    always_comb begin
        next_mask1 = mask1;
        next_mask2 = mask2;
        next_mode1 = mode1;
        next_mode2 = mode2;
        if (reg_wr_in) begin
            case (reg_addr_in)
                `RSIM_ADDR_MASK1: next_mask1 = reg_wdata_in;
                `RSIM_ADDR_MASK2: next_mask2 = reg_wdata_in[`RSIM_SLIP_MASK_BIT];
                `RSIM_ADDR_MODE1: next_mode1 = reg_wdata_in;
                `RSIM_ADDR_MODE2: next_mode2 = reg_wdata_in;
                default: next_mask1 = mask1;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            mask1 <= `RSIM_MASK_RESET;
            mask2 <= 1'b0;
            mode1 <= `RSIM_MODE_RESET;
            mode2 <= `RSIM_MODE_RESET;
        end else begin
            mask1 <= next_mask1;
            mask2 <= next_mask2;
            mode1 <= next_mode1;
            mode2 <= next_mode2;
        end
    end

    // ------------------------------------------------------------
    // Interrupt sources
    // ------------------------------------------------------------
    logic [NUM_SRC-1:0] src_flag;
    logic [NUM_SRC-1:0] src_clear;
    logic [NUM_SRC-1:0] src_enable;
    logic [NUM_SRC-1:0] pending;
    logic [2*NUM_SRC-1:0] src_mode;
    logic next_irq;
    logic irq;

    // Slip has no mode field, so it stays on rising edge
    assign src_mode = {2'h0, mode2, mode1};
    assign src_flag = {slip_flag, err_status};
    assign src_clear = {rd_slip, {8{rd_err}}};
    // enable bit i guards flag bit i
    assign src_enable = {mask2, mask1};

    genvar gi;
    generate
        for (gi = 0; gi < NUM_SRC; gi = gi + 1) begin : g_src
            rsim_trigger u_trig (
                .clock_in(clock_in),
                .rst_in(rst_in),
                .flag_in(src_flag[gi]),
                .mode_in(src_mode[2*gi+1:2*gi]),
                .clear_in(src_clear[gi]),
                .pending_out(pending[gi])
            );
        end
    endgenerate

    assign next_irq = |(pending & src_enable);

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            irq <= 1'b0;
        end else begin
            irq <= next_irq;
        end
    end

    assign irq_out = irq;

    // ------------------------------------------------------------
    // Register read port
    // ------------------------------------------------------------
    logic [7:0] rdata;
    logic [7:0] next_rdata;

    always_comb begin
        next_rdata = rdata;
        if (reg_rd_in) begin
            case (reg_addr_in)
                `RSIM_ADDR_RATE: next_rdata = {5'h00, rate[1], 1'b0, rate[0]};
                `RSIM_ADDR_ERR: next_rdata = err_status;
                `RSIM_ADDR_SLIP: next_rdata = {7'h00, slip_flag};
                `RSIM_ADDR_MASK1: next_rdata = mask1;
                `RSIM_ADDR_MASK2: next_rdata = {7'h00, mask2};
                `RSIM_ADDR_MODE1: next_rdata = mode1;
                `RSIM_ADDR_MODE2: next_rdata = mode2;
                default: next_rdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            rdata <= 8'h00;
        end else begin
            rdata <= next_rdata;
        end
    end

    assign reg_rdata_out = rdata;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (rst_in);

    sequence s_slow_frame;
        locked && meas != RSIM_MEAS_IDLE && frame_strobe_in && period_cnt >= TH_512;
    endsequence

    sequence s_rise_cs;
        !err_status.cs_crc ##1 err_status.cs_crc && mode2[7:6] == 2'h0;
    endsequence

    a_rate_slow_frame: assert property (s_slow_frame ##1 locked |-> rate == RSIM_RATE_512)
        else $error("slow frame did not give 512x rate");
    a_rate_unlock: assert property (!locked |=> rate == RSIM_RATE_NONE)
        else $error("rate code not cleared on unlock");
    a_lock_loss: assert property (!rx_cond_in.synth_locked ##1 rd_err |=> reg_rdata_out[2])
        else $error("lock loss not reported");
    a_rate_read_zero: assert property (reg_rd_in && reg_addr_in == `RSIM_ADDR_RATE |=> reg_rdata_out[7:3] == 5'h00 && !reg_rdata_out[1])
        else $error("unused rate bits not zero");
    a_slip_port_a: assert property (slip_in.port_a_src && slip_in.port_a_slave && slip_in.port_a_slip |=> slip_flag)
        else $error("port A slip not flagged");
    a_slip_no_slave: assert property (!slip_in.port_a_slave && !slip_in.port_b_slave && !slip_flag |=> !slip_flag)
        else $error("slip flagged without slave port");
    a_mask_gate: assert property (mask1 == 8'h00 && !mask2 |=> !irq_out)
        else $error("interrupt while all sources masked");
    // Own disable, otherwise the default one would hide the reset cycles
    a_mask_reset: assert property (disable iff (1'b0) rst_in |=> mask1 == 8'h00 && !mask2)
        else $error("mask not cleared by reset");
    a_rise_irq: assert property (s_rise_cs ##1 mask1[7] |=> irq_out)
        else $error("rising edge did not raise interrupt");
    a_level_follow: assert property (mode1[1:0] == 2'h2 && err_status.xfer_done ##1 mask1[0] |=> irq_out)
        else $error("level source did not raise interrupt");
endmodule
`default_nettype wire

// >>> core/rsim_trigger.sv
`timescale 1ns/10ps
`default_nettype none
module rsim_trigger
    import rsim_pkg::*;
(
    input wire logic clock_in,
    input wire logic rst_in,
    input wire logic flag_in,
    input wire logic [1:0] mode_in,
    input wire logic clear_in,
    output logic pending_out
);
    logic prev;
    logic pending;
    logic next_pending;

    always_comb begin
        next_pending = pending;
        case (rsim_trig_type'(mode_in))
            RSIM_TRIG_RISE: begin
                // New edge beats a clear in the same cycle
                if (flag_in && !prev) begin
                    next_pending = 1'b1;
                end else if (clear_in) begin
                    next_pending = 1'b0;
                end
            end
            RSIM_TRIG_FALL: begin
                if (!flag_in && prev) begin
                    next_pending = 1'b1;
                end else if (clear_in) begin
                    next_pending = 1'b0;
                end
            end
            RSIM_TRIG_LEVEL: begin
                next_pending = flag_in;
            end
            default: begin
                next_pending = 1'b0;
            end
        endcase
    end

    always_ff @(posedge clock_in) begin
        if (rst_in) begin
            prev <= 1'b0;
            pending <= 1'b0;
        end else begin
            prev <= flag_in;
            pending <= next_pending;
        end
    end

    assign pending_out = pending;
endmodule
`default_nettype wire

// >>> sim/rsim_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module rsim_host_model
    import rsim_pkg::*;
(
    input wire logic clock_in,
    input wire logic [7:0] reg_rdata_in,
    output logic [7:0] reg_addr_out,
    output logic reg_wr_out,
    output logic [7:0] reg_wdata_out,
    output logic reg_rd_out
);
    initial begin
        reg_addr_out = 8'h00;
        reg_wr_out = 1'b0;
        reg_wdata_out = 8'h00;
        reg_rd_out = 1'b0;
    end

    // ----------------------------------------
    // Register port cycles
    // ----------------------------------------
    // Released lines show the inverse, so stale values never look valid
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        reg_addr_out <= addr;
        reg_wdata_out <= data;
        reg_wr_out <= 1'b1;
        @(posedge clock_in);
        reg_wr_out <= 1'b0;
        reg_addr_out <= ~addr;
        reg_wdata_out <= ~data;
        @(posedge clock_in);
    endtask

    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        reg_addr_out <= addr;
        reg_rd_out <= 1'b1;
        @(posedge clock_in);
        reg_rd_out <= 1'b0;
        reg_addr_out <= ~addr;
        @(posedge clock_in);
        data = reg_rdata_in;
    endtask

    task automatic rate_read(output logic [1:0] code, output logic [7:0] raw);
        rd(8'h13, raw);
        code = {raw[2], raw[0]};
    endtask
endmodule
`default_nettype wire

// >>> sim/tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "rsim_map.svh"
module tb
    import rsim_pkg::*;
;
    localparam int TIMEOUT_CYC = 2000;
    logic clock_in = 1'b0;
    logic rst_in = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d, f;
    logic reg_wr, reg_rd, frame_strobe, irq, exp;
    logic [1:0] rate, code, want;
    rsim_rx_cond_type rx_cond;
    rsim_slip_type slip;
    int failures = 0;
    int checks = 0;
    int cycles = 0;
    int seed = 33394;
    int periods [6] = '{100, 370, 371, 740, 741, 800};

    always #12.5 clock_in = ~clock_in;

    rsim_status_irq #(.FRAME_TIMEOUT_CYC(TIMEOUT_CYC)) rsim_status_irq_inst (
        .clock_in(clock_in), .rst_in(rst_in), .reg_addr_in(reg_addr),
        .reg_wr_in(reg_wr), .reg_wdata_in(reg_wdata), .reg_rd_in(reg_rd),
        .reg_rdata_out(reg_rdata), .rx_cond_in(rx_cond), .frame_strobe_in(frame_strobe),
        .slip_in(slip), .recovered_clock_rate_out(rate), .irq_out(irq)
    );

    rsim_host_model rsim_host_model_inst (
        .clock_in(clock_in), .reg_rdata_in(reg_rdata), .reg_addr_out(reg_addr),
        .reg_wr_out(reg_wr), .reg_wdata_out(reg_wdata), .reg_rd_out(reg_rd)
    );

    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] want);
        checks++;
        if (got !== want) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic chk_bit(input logic got, input logic want);
        chk_byte({7'h00, got}, {7'h00, want});
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clock_in);
    endtask

    task automatic frame(input int gap);
        repeat (gap - 1) @(posedge clock_in);
        frame_strobe <= 1'b1;
        @(posedge clock_in);
        frame_strobe <= 1'b0;
    endtask

    // Lock loss is made by the decoder or by the synth, picked by sel
    function automatic rsim_rx_cond_type cond_of(input logic [7:0] s, input logic sel);
        return {s[7:3], ~(s[2] & ~sel), ~(s[2] & sel), s[1:0]};
    endfunction

    // Counter restarts at zero on a strobe, so a gap of N cycles counts N-1
    function automatic logic [1:0] exp_rate(input int p);
        return (p > `RSIM_PERIOD_512_CYC) ? 2'h3 : (p > `RSIM_PERIOD_256_CYC) ? 2'h2 : 2'h1;
    endfunction

    task automatic test_done();
        if (failures == 0 && checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 60000) begin
            failures++;
            test_done();
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        rx_cond = cond_of(8'h00, 1'b0);
        slip = '0;
        frame_strobe = 1'b0;
        repeat (10) @(posedge clock_in);
        rst_in <= 1'b0;
        for (int a = 8'h16; a <= 8'h19; a++) begin
            rsim_host_model_inst.rd(a[7:0], d);
            chk_byte(d, 8'h00);
        end
        rsim_host_model_inst.rd(8'h1a, d);
        chk_byte(d, 8'h00);
        f = 8'($random(seed));
        rsim_host_model_inst.wr(8'h16, f);
        rsim_host_model_inst.rd(8'h16, d);
        chk_byte(d, f);
        rsim_host_model_inst.wr(8'h17, ~f);
        rsim_host_model_inst.rd(8'h17, d);
        chk_byte(d, {7'h00, ~f[0]});
        rsim_host_model_inst.wr(8'h14, 8'hff);
        rsim_host_model_inst.rd(8'h14, d);
        chk_byte(d, 8'h00);
        rsim_host_model_inst.wr(8'h16, 8'h00);
        rsim_host_model_inst.wr(8'h17, 8'h00);
        // Random status levels through the error register
        for (int k = 0; k < 24; k++) begin
            f = 8'($random(seed));
            rx_cond <= cond_of(f, k[0]);
            tick(2);
            rsim_host_model_inst.rd(8'h14, d);
            chk_byte(d, f);
        end
        // Every trigger mode on each of the eight status sources, masked then unmasked
        for (int m = 0; m < 4; m++) begin
            rsim_host_model_inst.wr(8'h18, {4{m[1:0]}});
            rsim_host_model_inst.wr(8'h19, {4{m[1:0]}});
            for (int i = 0; i < 8; i++) begin
                f = 8'h01 << i;
                rx_cond <= cond_of(m == 1 ? f : 8'h00, 1'b0);
                tick(4);
                rsim_host_model_inst.rd(8'h14, d);
                rsim_host_model_inst.wr(8'h16, ~f);
                rx_cond <= cond_of(m == 1 ? 8'h00 : f, 1'b0);
                tick(4);
                chk_bit(irq, 1'b0);
                rsim_host_model_inst.wr(8'h16, f);
                tick(3);
                chk_bit(irq, m != 3);
                rsim_host_model_inst.rd(8'h14, d);
                tick(3);
                chk_bit(irq, m == 2);
                rx_cond <= cond_of(m == 1 ? f : 8'h00, 1'b0);
                tick(4);
                chk_bit(irq, 1'b0);
            end
        end
        rx_cond <= cond_of(8'h00, 1'b0);
        rsim_host_model_inst.wr(8'h16, 8'h00);
        rsim_host_model_inst.wr(8'h18, 8'h00);
        rsim_host_model_inst.wr(8'h19, 8'h00);
        // Rising edge on an already enabled source
        rsim_host_model_inst.wr(8'h16, 8'h80);
        rx_cond <= cond_of(8'h80, 1'b0);
        tick(4);
        chk_bit(irq, 1'b1);
        rsim_host_model_inst.rd(8'h14, d);
        rx_cond <= cond_of(8'h00, 1'b0);
        rsim_host_model_inst.wr(8'h16, 8'h00);
        rsim_host_model_inst.wr(8'h17, 8'h01);
        // All port source, mode and slip combinations
        for (int v = 0; v < 64; v++) begin
            slip <= {v[5], v[4], 1'b0, v[3], v[2], 1'b0};
            tick(2);
            rsim_host_model_inst.rd(8'h15, d);
            slip <= {v[5], v[4], v[1], v[3], v[2], v[0]};
            tick(1);
            slip <= {v[5], v[4], 1'b0, v[3], v[2], 1'b0};
            exp = v[5] ? (v[4] & v[1]) : (v[3] & v[2] & v[0]);
            tick(4);
            chk_bit(irq, exp);
            rsim_host_model_inst.rd(8'h15, d);
            chk_byte(d, {7'h00, exp});
            tick(3);
            chk_bit(irq, 1'b0);
        end
        // Frame periods around both thresholds, unlock between them
        foreach (periods[p]) begin
            rx_cond <= cond_of(8'h04, p[0]);
            tick(3);
            chk_byte({6'h00, rate}, 8'h00);
            rx_cond <= cond_of(8'h00, 1'b0);
            tick(2);
            frame(2);
            frame(periods[p]);
            tick(2);
            want = exp_rate(periods[p]);
            chk_byte({6'h00, rate}, {6'h00, want});
            rsim_host_model_inst.rate_read(code, d);
            chk_byte({6'h00, code}, {6'h00, want});
            chk_byte(d, {5'h00, want[1], 1'b0, want[0]});
        end
        tick(TIMEOUT_CYC + 4);
        chk_byte({6'h00, rate}, 8'h00);
        // Reset in mid-run must mask everything again
        rsim_host_model_inst.wr(8'h16, 8'hff);
        rst_in <= 1'b1;
        tick(2);
        rst_in <= 1'b0;
        rsim_host_model_inst.rd(8'h16, d);
        chk_byte(d, 8'h00);
        chk_bit(irq, 1'b0);
        test_done();
    end
endmodule
`default_nettype wire
